// *** rtl/cps_regs.vh ***
// Function
// RULE_01: two bits select off, thermistor or board mode
// RULE_02: board overheat holds both switches off, flags fault
// RULE_03: thermistor pauses charging outside window, auto-resumes
// RULE_04: one hour precharge timer, host may disable
// RULE_05: fast-charge timer starts on entering fast charge
// RULE_06: new cycle or enable toggles clear timer
// RULE_07: reset lands in default mode, default registers
// RULE_08: any register write enters host mode
// RULE_09: host kicks watchdog; expiry returns default mode
// RULE_10: watchdog count pauses without input supply
// RULE_11: input or battery reinsertion, reset bit: default; code: insertion counts only while the other source is absent
// RULE_12: battery switch on above undervoltage level
// RULE_13: programmable overcurrent trips after 60us, hiccup
// RULE_14: fixed overcurrent trips battery switch at once
// RULE_15: battery below undervoltage level opens switch
// RULE_16: low system voltage arms guard, halves limit
// RULE_17: input path trip immediate or delayed hiccup
// RULE_18: battery path trip immediate or delayed hiccup
// RULE_19: first tripping path governs hiccup timing; code: an immediate trip cuts short a pending delayed trip
// RULE_20: 256us low alert pulse on events, faults
// RULE_21: faults latch, read clears; thermistor bit live
// RULE_22: board pulls alert up, 300k or more
// RULE_23: precharge timeout stops charge, flags fault
// RULE_24: all timing from pclk, reset clears all
`ifndef CPS_REGS_VH
`define CPS_REGS_VH

// register byte offsets
`define CPS_OFS_CTRL 8'h00
`define CPS_OFS_POC 8'h04
`define CPS_OFS_TMR 8'h08
`define CPS_OFS_LIM 8'h0C
`define CPS_OFS_FLT 8'h10
`define CPS_OFS_STAT 8'h14

// control register fields
`define CPS_CTL_CHG_EN 0
`define CPS_CTL_SUSP 1
`define CPS_CTL_SNS_EN 2
`define CPS_CTL_OTP_DIS 3
`define CPS_CTL_ST_EN 4
`define CPS_CTL_RST 5'h1_5
// power-on config fields
`define CPS_POC_KICK 6
`define CPS_POC_RRST 7
// timer control fields and reset
`define CPS_TMR_RST 6'h1_2
// limit register reset: dsc 4b, uvlo 3b, iin 3b
`define CPS_LIM_RST 10'h3_A8
// fault bits
`define CPS_F_WDT 0
`define CPS_F_THERM 1
`define CPS_F_TMO 2
`define CPS_F_OC 3
`define CPS_F_SC 4
`define CPS_F_UV 5

// timing, all in 40 bits
`define CPS_PCLK_MHZ 40'd20
`define CPS_T_DLY_US 40'd60
`define CPS_T_HIC_US 40'd800
`define CPS_T_PLS_US 40'd256
`define CPS_T_PRE_S 40'd3600
`define CPS_T_FAST_S 40'd3600
`define CPS_T_WDT_S 40'd40
`define CPS_DLY_CYC (`CPS_T_DLY_US * `CPS_PCLK_MHZ)
`define CPS_HIC_CYC (`CPS_T_HIC_US * `CPS_PCLK_MHZ)
`define CPS_PLS_CYC (`CPS_T_PLS_US * `CPS_PCLK_MHZ)
`define CPS_PRE_CYC (`CPS_T_PRE_S * 40'd1000000 * `CPS_PCLK_MHZ)
`define CPS_FAST_CYC (`CPS_T_FAST_S * 40'd1000000 * `CPS_PCLK_MHZ)
`define CPS_WDT_CYC (`CPS_T_WDT_S * 40'd1000000 * `CPS_PCLK_MHZ)

`endif

// *** rtl/cps_sync.v ***
`timescale 1ns/1ps
// two-flop synchroniser for a bus of slow levels
module cps_sync #(
  parameter W = 12
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q; // first stage, read only by s2
  reg [W-1:0] s2_q; // settled copy

  // each bit is an independent level, no word coherence
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule

// *** rtl/cps_top.v ***
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "cps_regs.vh"
// charger protection supervisor with apb register slave
module cps_top #(
  parameter [39:0] DLY_CYC = `CPS_DLY_CYC,
  parameter [39:0] HIC_CYC = `CPS_HIC_CYC,
  parameter [39:0] PLS_CYC = `CPS_PLS_CYC,
  parameter [39:0] PRE_CYC = `CPS_PRE_CYC,
  parameter [39:0] FAST_CYC = `CPS_FAST_CYC,
  parameter [39:0] WDT_CYC = `CPS_WDT_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire vin_ok,
  input wire batt_present,
  input wire vbatt_above_pre,
  input wire vbatt_above_uvlo,
  input wire ntc_below_hot,
  input wire ntc_out_window,
  input wire vsys_low,
  input wire iin_over_prot,
  input wire iin_at_limit,
  input wire ibatt_over_fixed,
  input wire ibatt_over_limit,
  input wire charge_full,
  output wire input_switch_on,
  output wire battery_switch_on,
  output wire charge_on,
  output wire precharge_phase,
  output wire [3:0] discharge_current_limit,
  output wire [2:0] battery_undervoltage_level,
  output wire [2:0] input_current_limit,
  output wire alert_o,
  output wire alert_oe
);
  // hiccup states, one-hot
  localparam [2:0] HS_RUN = 3'b001;
  localparam [2:0] HS_WAIT = 3'b010;
  localparam [2:0] HS_OFF = 3'b100;

  wire [11:0] s; // synchronised comparator levels
  reg [11:0] sp_q; // previous sample, for edges
  reg [4:0] ctl_q; // control register
  reg [4:0] ctlp_q; // previous control, toggle detect
  reg [5:0] tmr_q; // watchdog period, fast timer select
  reg [9:0] lim_q; // analog limit codes
  reg [5:0] flt_q; // latched faults
  reg host_q; // 1 in host mode
  reg [39:0] wdt_q; // watchdog count
  reg [39:0] st_q; // safety timer count
  reg tmo_q; // safety timer expired
  reg pre_q; // precharge phase last cycle
  reg req_q; // charge request last cycle
  reg chg_q; // charging output
  reg [2:0] hs_q; // hiccup state
  reg [2:0] hs_d;
  reg [39:0] hc_q; // hiccup count
  reg [39:0] hc_d;
  reg both_q; // trip cuts both switches
  reg both_d;
  reg [39:0] pl_q; // alert pulse count
  reg al_q; // alert pin driven low
  reg therm_q; // thermistor fault last cycle
  reg in_sw_q;
  reg bat_sw_q;
  reg [3:0] dsc_q;
  reg [31:0] rd_q; // read data, loaded in setup
  reg [31:0] rmux;

  // pins enter through the synchroniser only
  cps_sync #(.W(12)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({charge_full, ibatt_over_limit, ibatt_over_fixed,
        iin_at_limit, iin_over_prot, vsys_low, ntc_out_window,
        ntc_below_hot, vbatt_above_uvlo, vbatt_above_pre,
        batt_present, vin_ok}),
    .q(s)
  );

  wire vin = s[0];
  wire bat = s[1];
  wire above_pre = s[2];
  wire above_uv = s[3];
  wire ntc_hot = s[4];
  wire ntc_out = s[5];
  wire sys_low = s[6];
  wire iin_prot = s[7];
  wire iin_lim = s[8];
  wire ib_fix = s[9];
  wire ib_lim = s[10];
  wire full = s[11];
  wire vin_rise = vin & ~sp_q[0];
  wire bat_rise = bat & ~sp_q[1];

  // apb decode; slave never waits
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire hit = (paddr == `CPS_OFS_CTRL) | (paddr == `CPS_OFS_POC) |
             (paddr == `CPS_OFS_TMR) | (paddr == `CPS_OFS_LIM) |
             (paddr == `CPS_OFS_FLT) | (paddr == `CPS_OFS_STAT);
  wire wr = acc & pwrite & hit;
  wire wr_poc = wr & (paddr == `CPS_OFS_POC);
  wire rd_flt = acc & ~pwrite & (paddr == `CPS_OFS_FLT);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = rd_q;

  // RULE_09 watchdog kick
  wire kick = wr_poc & pwdata[`CPS_POC_KICK];
  wire rrst = wr_poc & pwdata[`CPS_POC_RRST];

  // watchdog limit: unit, doubled per select step
  wire [1:0] wsel = tmr_q[5:4];
  wire [1:0] wsh = wsel - 2'd1;
  wire [39:0] wlim = WDT_CYC << wsh;
  // RULE_10 count only with input present
  wire wrun = host_q & (wsel != 2'd0) & vin;
  wire wexp = wrun & (wdt_q == wlim - 40'd1);

  // RULE_11 fall back to default on these events
  wire go_def = wexp | rrst | (vin_rise & ~bat) |
                (bat_rise & ~vin);

  // RULE_01 temperature sense selection
  wire ntc_mode = ctl_q[`CPS_CTL_SNS_EN] & ctl_q[`CPS_CTL_OTP_DIS];
  wire otp_mode = ctl_q[`CPS_CTL_SNS_EN] & ~ctl_q[`CPS_CTL_OTP_DIS];
  // RULE_02 board overheat while below hot threshold
  wire otp_hold = otp_mode & ntc_hot;
  wire hic_off = hs_q[2];

  // charge request before the thermistor window
  wire req = ctl_q[`CPS_CTL_CHG_EN] & ~ctl_q[`CPS_CTL_SUSP] &
             vin & bat & ~otp_hold & ~tmo_q & ~hic_off;
  // RULE_03 thermistor only pauses an active charge
  wire ntc_stop = ntc_mode & req & ntc_out;
  wire chg = req & ~ntc_stop & ~full;
  wire pre = chg & ~above_pre;
  wire therm = otp_hold | ntc_stop;

  // RULE_06 timer clear sources
  wire tgl = (ctl_q[`CPS_CTL_CHG_EN] != ctlp_q[`CPS_CTL_CHG_EN]) |
             (ctl_q[`CPS_CTL_SUSP] != ctlp_q[`CPS_CTL_SUSP]);
  wire new_cyc = req & ~req_q;
  // RULE_05 restart count on precharge to fast change
  wire fast_in = pre_q & ~pre & chg;
  // RULE_04 one hour while precharge, else selected
  wire [39:0] slim = pre ? PRE_CYC : (FAST_CYC << tmr_q[2:1]);
  wire srun = chg & ctl_q[`CPS_CTL_ST_EN];
  wire sexp = srun & (st_q == slim - 40'd1);

  // hiccup triggers
  // RULE_14 fixed limit and input guard trip at once
  wire trip_now = ib_fix | (sys_low & iin_prot);
  // RULE_13 programmable limit and input limit wait
  wire trip_slow = ib_lim | (sys_low & iin_lim);

  // hiccup sequencer, immediate trip wins over a pending delay
  always @* begin
    hs_d = hs_q;
    hc_d = hc_q + 40'd1;
    both_d = both_q;
    case (hs_q)
      HS_RUN: begin
        hc_d = 40'd0;
        // RULE_19 immediate trip wins, also over a pending delayed one
        if (trip_now) begin
          hs_d = HS_OFF;
          // RULE_17 short trips cut both switches
          both_d = sys_low;
        end else if (trip_slow) begin
          hs_d = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (trip_now) begin
          hs_d = HS_OFF;
          hc_d = 40'd0;
          both_d = sys_low;
        end else if (!trip_slow) begin
          // overload went away before the delay
          hs_d = HS_RUN;
        end else if (hc_q == DLY_CYC - 40'd1) begin
          // RULE_18 delayed trip after 60us
          hs_d = HS_OFF;
          hc_d = 40'd0;
          both_d = sys_low;
        end
      end
      HS_OFF: begin
        // RULE_17 retry once the hiccup interval ends
        if (hc_q == HIC_CYC - 40'd1) begin
          hs_d = HS_RUN;
          hc_d = 40'd0;
        end
      end
      default: begin
        hs_d = HS_RUN;
        hc_d = 40'd0;
      end
    endcase
  end

  // fault sets and still-active conditions
  wire trip_in = ~hs_q[2] & hs_d[2];
  wire [5:0] fset = {bat & ~above_uv, trip_in & sys_low,
                     trip_in & ~sys_low, sexp, 1'b0, wexp};
  wire [5:0] fcond = {bat & ~above_uv, ~hs_q[0] & sys_low,
                      ~hs_q[0], tmo_q, 1'b0, 1'b0};
  // RULE_21 read clears only ended faults; set wins
  wire [5:0] flt_d = (flt_q & ~({6{rd_flt}} & ~fcond)) | fset;
  wire [5:0] fview = {flt_q[5:2], therm, flt_q[0]};

  // RULE_20 alert sources
  wire ev = vin_rise | (full & ~sp_q[11]) | (chg != chg_q) |
            (pre != pre_q) | (|(fset & ~flt_q)) |
            (therm & ~therm_q);

  // read mux, sampled during the setup cycle
  always @* begin
    rmux = 32'h0000_0000;
    case (paddr)
      `CPS_OFS_CTRL: rmux[4:0] = ctl_q;
      `CPS_OFS_TMR: rmux[5:0] = tmr_q;
      `CPS_OFS_LIM: rmux[9:0] = lim_q;
      `CPS_OFS_FLT: rmux[5:0] = fview;
      `CPS_OFS_STAT: rmux[7:0] = {full, bat_sw_q, in_sw_q,
                                  ~hs_q[0], vin, pre_q, chg_q,
                                  host_q};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // apb read data and register writes
  // RULE_24 every counter and latch cleared by reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 32'h0000_0000;
      ctl_q <= `CPS_CTL_RST;
      ctlp_q <= `CPS_CTL_RST;
      tmr_q <= `CPS_TMR_RST;
      lim_q <= `CPS_LIM_RST;
      // RULE_07 start in default mode
      host_q <= 1'b0;
    end else begin
      if (setup && !pwrite) begin
        rd_q <= rmux;
      end
      ctlp_q <= ctl_q;
      if (go_def) begin
        // default mode restores every setting
        ctl_q <= `CPS_CTL_RST;
        tmr_q <= `CPS_TMR_RST;
        lim_q <= `CPS_LIM_RST;
        host_q <= 1'b0;
      end else if (wr) begin
        // RULE_08 any write to a mapped register enters host mode
        host_q <= 1'b1;
        if (paddr == `CPS_OFS_CTRL) begin
          ctl_q <= pwdata[4:0];
        end
        if (paddr == `CPS_OFS_TMR) begin
          tmr_q <= pwdata[5:0];
        end
        if (paddr == `CPS_OFS_LIM) begin
          lim_q <= pwdata[9:0];
        end
      end
    end
  end

  // watchdog counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_q <= 40'd0;
    end else if (kick || go_def || !host_q || wsel == 2'd0) begin
      wdt_q <= 40'd0;
    end else if (wrun) begin
      // RULE_09 count toward expiry
      wdt_q <= wdt_q + 40'd1;
    end
  end

  // safety timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= 40'd0;
      tmo_q <= 1'b0;
    end else begin
      // RULE_06 clear on new cycle or toggles
      if (new_cyc || tgl || fast_in) begin
        st_q <= 40'd0;
      end else if (srun) begin
        st_q <= st_q + 40'd1;
      end
      // RULE_23 expiry stops the charge until a toggle
      if (sexp) begin
        tmo_q <= 1'b1;
      end else if (tgl) begin
        tmo_q <= 1'b0;
      end
    end
  end

  // hiccup state and status history
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q <= HS_RUN;
      hc_q <= 40'd0;
      both_q <= 1'b0;
      sp_q <= 12'h000;
      req_q <= 1'b0;
      pre_q <= 1'b0;
      chg_q <= 1'b0;
      therm_q <= 1'b0;
      flt_q <= 6'h00;
    end else begin
      hs_q <= hs_d;
      hc_q <= hc_d;
      both_q <= both_d;
      sp_q <= s;
      req_q <= req;
      pre_q <= pre;
      chg_q <= chg;
      therm_q <= therm;
      flt_q <= flt_d;
    end
  end

  // alert pulse, retriggered by any new event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pl_q <= 40'd0;
      al_q <= 1'b0;
    end else begin
      // RULE_20 hold the pin low for the pulse time
      al_q <= ev | (pl_q > 40'd1);
      if (ev) begin
        pl_q <= PLS_CYC;
      end else if (pl_q != 40'd0) begin
        pl_q <= pl_q - 40'd1;
      end
    end
  end

  // switch drive and analog limit codes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sw_q <= 1'b0;
      bat_sw_q <= 1'b0;
      dsc_q <= 4'h0;
    end else begin
      // RULE_02 board overheat opens both paths
      in_sw_q <= vin & ~ctl_q[`CPS_CTL_SUSP] & ~otp_hold &
                 ~(hic_off & both_q);
      // RULE_12 battery switch on above undervoltage
      // RULE_15 and off below it
      bat_sw_q <= bat & above_uv & ~otp_hold & ~hic_off;
      // RULE_16 halve discharge limit while system is low
      dsc_q <= sys_low ? {1'b0, lim_q[3:1]} : lim_q[3:0];
    end
  end

  assign input_switch_on = in_sw_q;
  assign battery_switch_on = bat_sw_q;
  assign charge_on = chg_q;
  assign precharge_phase = pre_q;
  assign discharge_current_limit = dsc_q;
  assign battery_undervoltage_level = lim_q[6:4];
  assign input_current_limit = lim_q[9:7];
  // open drain: only ever pulls low
  // RULE_22 board supplies the pull-up
  assign alert_o = 1'b0;
  assign alert_oe = al_q;
endmodule

// *** tb/cps_host_model.sv ***
`timescale 1ns/1ps
// host end of the alert pin: pull-up plus pulse timer
module cps_host_model (
  input wire pclk,
  input wire alert_o,
  input wire alert_oe,
  output logic [15:0] min_len
);
  logic [15:0] run_q;
  wire int_n = alert_oe ? alert_o : 1'b1;
  initial begin
    run_q = 16'h0;
    min_len = 16'hFFFF;
  end
  // shortest low pulse seen
  always @(posedge pclk) begin
    if (!int_n) begin
      run_q <= run_q + 16'h1;
    end else begin
      if (run_q != 16'h0 && run_q < min_len) begin
        min_len <= run_q;
      end
      run_q <= 16'h0;
    end
  end
endmodule

// *** tb/cps_top_monitor.sv ***
`timescale 1ns/1ps
// pin-level watcher for the protection timing of the supervisor
module cps_top_monitor #(
  parameter [39:0] PLS_CYC = 40'd5120
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire vin_ok,
  input wire batt_present,
  input wire vbatt_above_uvlo,
  input wire ntc_below_hot,
  input wire vsys_low,
  input wire iin_over_prot,
  input wire ibatt_over_fixed,
  input wire ibatt_over_limit,
  input wire input_switch_on,
  input wire battery_switch_on,
  input wire [3:0] discharge_current_limit,
  input wire [2:0] battery_undervoltage_level,
  input wire [2:0] input_current_limit,
  input wire alert_oe
);
  // alert low run length
  logic [39:0] run_q;
  // cycles of calm battery-only supply
  logic [5:0] quiet_q;
  wire quiet = batt_present && !vin_ok && vbatt_above_uvlo && !ntc_below_hot
    && !vsys_low && !iin_over_prot && !ibatt_over_fixed && !ibatt_over_limit;
  // saturate so a long calm spell never wraps back to the trigger value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 40'h0;
      quiet_q <= 6'h0;
    end else begin
      run_q <= alert_oe ? run_q + 40'h1 : 40'h0;
      quiet_q <= !quiet ? 6'h0 : (quiet_q == 6'h3F ? quiet_q : quiet_q + 6'h1);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // short on input path, both switches must drop
  sequence s_short;
    (vsys_low && iin_over_prot)[*5];
  endsequence
  // programmable limit crossed while switch conducts
  sequence s_lim_rise;
    $rose(ibatt_over_limit) && battery_switch_on && vbatt_above_uvlo
      && !ibatt_over_fixed && !vsys_low;
  endsequence
  AST_RST_VAL: assert property (
    $rose(presetn) |-> battery_undervoltage_level == 3'h2
      && input_current_limit == 3'h7)
    else $error("limit fields not at default");
  AST_FIXED_TRIP: assert property (
    $rose(ibatt_over_fixed) ##1 ibatt_over_fixed[*3] |=> !battery_switch_on)
    else $error("fixed limit trip late");
  AST_SHORT_OFF: assert property (
    s_short |-> !input_switch_on && !battery_switch_on)
    else $error("short did not open switches");
  AST_SLOW_HOLD: assert property (
    s_lim_rise |=> battery_switch_on[*3])
    else $error("slow trip skipped its delay");
  AST_SLOW_TRIP: assert property (
    ibatt_over_limit[*8] |-> ##[0:8] !battery_switch_on)
    else $error("slow trip missing");
  AST_UV_OFF: assert property (
    (!vbatt_above_uvlo && !vin_ok)[*4] |-> !battery_switch_on)
    else $error("switch on below uv level");
  AST_BAT_ON: assert property (
    quiet_q == 6'h28 |-> battery_switch_on)
    else $error("battery switch not on");
  AST_HALF_LIMIT: assert property (
    (!vsys_low && !psel)[*4] ##1 (vsys_low && !psel)[*4]
      |-> discharge_current_limit == ($past(discharge_current_limit, 4) >> 1))
    else $error("limit not halved");
  AST_ALERT_LEN: assert property (
    $fell(alert_oe) |-> run_q >= PLS_CYC)
    else $error("alert pulse too short");
endmodule

bind cps_top cps_top_monitor #(.PLS_CYC(PLS_CYC)) cps_top_monitor_i (
  .pclk, .presetn, .psel, .vin_ok, .batt_present, .vbatt_above_uvlo,
  .ntc_below_hot, .vsys_low, .iin_over_prot, .ibatt_over_fixed,
  .ibatt_over_limit, .input_switch_on, .battery_switch_on,
  .discharge_current_limit, .battery_undervoltage_level,
  .input_current_limit, .alert_oe
);

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] rd;
  logic se;
  // condition inputs of the analog side
  logic vin = 0, bat = 1, pre = 1, uv = 1, hot = 0, win = 0;
  logic vsl = 0, iop = 0, ial = 0, ibf = 0, ibl = 0, full = 0;
  wire [31:0] prdata;
  wire pready, pslverr, isw, bsw, chg, prc, alert_o, alert_oe;
  wire [3:0] dlim;
  wire [2:0] uvl, icl;
  wire [15:0] minl;
  wire [31:0] ob = {28'h0, isw, bsw, chg, prc};
  integer miscompares = 0;
  integer tests_run = 0;
  always #25 pclk = ~pclk;
  cps_top #(.DLY_CYC(40'd4), .HIC_CYC(40'd20), .PLS_CYC(40'd8),
    .PRE_CYC(40'd50), .FAST_CYC(40'd40), .WDT_CYC(40'd30)) cps_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vin_ok(vin), .batt_present(bat),
    .vbatt_above_pre(pre), .vbatt_above_uvlo(uv), .ntc_below_hot(hot),
    .ntc_out_window(win), .vsys_low(vsl), .iin_over_prot(iop),
    .iin_at_limit(ial), .ibatt_over_fixed(ibf), .ibatt_over_limit(ibl),
    .charge_full(full), .input_switch_on(isw), .battery_switch_on(bsw),
    .charge_on(chg), .precharge_phase(prc), .discharge_current_limit(dlim),
    .battery_undervoltage_level(uvl), .input_current_limit(icl),
    .alert_o(alert_o), .alert_oe(alert_oe));
  cps_host_model cps_host_model_i (.pclk(pclk), .alert_o(alert_o),
    .alert_oe(alert_oe), .min_len(minl));
  task automatic cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s got %h", $time, m, g);
    end
  endtask
  // one apb transfer; trailing edge keeps back-to-back strobes apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] k, e,
    input string m);
    apb(0, a, 0);
    chk(rd & k, e, m);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_regs;
    rc(8'h00, ALL, 32'h15, "ctrl");
    rc(8'h08, ALL, 32'h12, "tmr");
    rc(8'h0C, ALL, 32'h3A8, "lim");
    rc(8'h04, ALL, 32'h0, "poc");
    rc(8'h14, 32'h1, 32'h0, "default");
    rc(8'h20, ALL, 32'h0, "unmapped");
    chk({31'h0, se}, 32'h1, "slverr");
    wr(8'h0C, 32'h3A6);
    rc(8'h14, 32'h1, 32'h1, "host");
    chk({28'h0, dlim}, 32'h6, "dlim");
    cyc(4);
    vsl <= 1;
    cyc(5);
    chk({28'h0, dlim}, 32'h3, "half");
    vsl <= 0;
    $display("t_regs done");
  endtask
  task automatic t_wdt;
    cyc(60);
    rc(8'h14, 32'h1, 32'h1, "no vin hold");
    vin <= 1;
    cyc(20);
    wr(8'h04, 32'h40);
    cyc(20);
    rc(8'h14, 32'h1, 32'h1, "kicked");
    cyc(40);
    rc(8'h14, 32'h1, 32'h0, "expired");
    rc(8'h10, 32'h1, 32'h1, "wdt flag");
    rc(8'h10, 32'h1, 32'h0, "wdt clr");
    wr(8'h0C, 32'h3A6);
    wr(8'h04, 32'h80);
    rc(8'h0C, ALL, 32'h3A8, "reg reset");
    rc(8'h14, 32'h1, 32'h0, "reg reset mode");
    $display("t_wdt done");
  endtask
  task automatic t_chg;
    wr(8'h08, 32'h02);
    wr(8'h00, 32'h14);
    wr(8'h00, 32'h15);
    cyc(70);
    chk(ob & 32'h2, 32'h2, "fast");
    cyc(20);
    chk(ob & 32'h2, 32'h0, "fast tmo");
    rc(8'h10, 32'h4, 32'h4, "tmo flag");
    wr(8'h00, 32'h04);
    wr(8'h00, 32'h05);
    hot <= 1;
    cyc(5);
    chk(ob & 32'hC, 32'h0, "board hot");
    rc(8'h10, 32'h2, 32'h2, "hot flag");
    hot <= 0;
    cyc(5);
    chk(ob & 32'hC, 32'hC, "hot end");
    rc(8'h10, 32'h2, 32'h0, "hot live");
    wr(8'h00, 32'h01);
    hot <= 1;
    cyc(5);
    chk(ob & 32'hC, 32'hC, "sense off");
    hot <= 0;
    wr(8'h00, 32'h0D);
    win <= 1;
    cyc(5);
    chk(ob & 32'h2, 32'h0, "win pause");
    win <= 0;
    cyc(5);
    chk(ob & 32'h2, 32'h2, "win resume");
    $display("t_chg done");
  endtask
  task automatic t_pre;
    wr(8'h00, 32'h14);
    pre <= 0;
    wr(8'h00, 32'h15);
    cyc(5);
    chk(ob & 32'h3, 32'h3, "pre");
    cyc(35);
    chk(ob & 32'h3, 32'h3, "pre run");
    cyc(20);
    chk(ob & 32'h3, 32'h0, "pre tmo");
    rc(8'h10, 32'h4, 32'h4, "tmo");
    rc(8'h10, 32'h4, 32'h4, "tmo held");
    pre <= 1;
    wr(8'h00, 32'h14);
    wr(8'h00, 32'h15);
    cyc(5);
    chk(ob & 32'h3, 32'h2, "restart");
    full <= 1;
    cyc(5);
    rc(8'h14, 32'h80, 32'h80, "full");
    full <= 0;
    $display("t_pre done");
  endtask
  task automatic t_ocp;
    vin <= 0;
    cyc(50);
    chk(ob & 32'h4, 32'h4, "bat on");
    ibf <= 1;
    cyc(5);
    chk(ob & 32'h4, 32'h0, "fixed");
    ibf <= 0;
    cyc(30);
    chk(ob & 32'h4, 32'h4, "hiccup end");
    rc(8'h10, 32'h8, 32'h8, "oc flag");
    rc(8'h10, 32'h8, 32'h0, "oc clr");
    ibl <= 1;
    cyc(3);
    chk(ob & 32'h4, 32'h4, "delay");
    cyc(8);
    chk(ob & 32'h4, 32'h0, "slow");
    ibl <= 0;
    cyc(30);
    uv <= 0;
    cyc(5);
    chk(ob & 32'h4, 32'h0, "uv");
    rc(8'h10, 32'h20, 32'h20, "uv flag");
    uv <= 1;
    vin <= 1;
    cyc(10);
    vsl <= 1;
    iop <= 1;
    cyc(5);
    chk(ob & 32'hC, 32'h0, "short");
    rc(8'h10, 32'h10, 32'h10, "sc flag");
    iop <= 0;
    vsl <= 0;
    chk({16'h0, minl}, 32'h8, "alert len");
    $display("t_ocp done");
  endtask
  task automatic t_ext;
    wr(8'h0C, 32'h0D5);
    chk({29'h0, uvl}, 32'h5, "uv code");
    chk({29'h0, icl}, 32'h1, "in limit code");
    cyc(30);
    rc(8'h10, 32'h10, 32'h10, "sc held");
    rc(8'h10, 32'h10, 32'h0, "sc clr");
    cyc(5);
    vsl <= 1;
    ial <= 1;
    cyc(3);
    chk(ob & 32'hC, 32'hC, "in delay");
    cyc(9);
    chk(ob & 32'hC, 32'h0, "in slow");
    chk({28'h0, dlim}, 32'h2, "half code");
    ial <= 0;
    vsl <= 0;
    rc(8'h10, 32'h10, 32'h10, "in slow flag");
    cyc(20);
    vin <= 0;
    bat <= 0;
    cyc(5);
    chk(ob & 32'h4, 32'h0, "no bat");
    bat <= 1;
    cyc(5);
    rc(8'h14, 32'h1, 32'h0, "reinsert");
    chk({29'h0, uvl}, 32'h2, "uv default");
    $display("t_ext done");
  endtask
  initial begin
    cyc(6);
    presetn <= 1;
    cyc(3);
    t_regs;
    t_wdt;
    t_chg;
    t_pre;
    t_ocp;
    t_ext;
    test_done;
  end
  // hang guard
  initial begin
    cyc(4000);
    miscompares++;
    $display("[ERR] %0t timeout", $time);
    test_done;
  end
endmodule
